// ### shared/crc_sig_regs.vh
// constants shared by the signature engine, its port checker and its bench
`ifndef CRC_SIG_REGS_VH
`define CRC_SIG_REGS_VH

// request kinds carried with every write
`define KIND_SEED 2'h0
`define KIND_BYTE 2'h1
`define KIND_WORD 2'h2
`define KIND_DWORD 2'h3

// mode select: 0 picks the 16-bit signature, 1 the 32-bit one
`define MODE_SHORT 1'h0
`define MODE_LONG 1'h1

// bytes folded per request kind
`define BYTES_BYTE 3'h1
`define BYTES_WORD 3'h2
`define BYTES_DWORD 3'h4
`define BYTES_ONE 3'h1

// generator polynomials in reflected form
`define POLY_LONG 32'hEDB8_8320
`define POLY_SHORT 32'h0000_8408

// signature values after reset
`define SEED_SHORT_RESET 16'hFFFF
`define SEED_LONG_RESET 32'hFFFF_FFFF

// request fifo layout and depth
`define REQ_WIDTH 36
`define REQ_DEPTH 4
`define REQ_DATA_LSB 0
`define REQ_DATA_MSB 31
`define REQ_MODE_BIT 32
`define REQ_REV_BIT 33
`define REQ_KIND_LSB 34
`define REQ_KIND_MSB 35

`endif

// ### design/crc_sig_fifo.v
// small request fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module crc_sig_fifo #(
   parameter WIDTH = 36,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clk, // system clock
   input wire rst, // synchronous reset, active high
   input wire in_valid, // producer offers a word
   output reg in_ready, // room for a word, registered
   input wire [WIDTH-1:0] in_data, // word offered
   output wire out_valid, // a word is waiting
   input wire out_ready, // consumer takes the word
   output wire [WIDTH-1:0] out_data // oldest word
);
   // full mark held at the counter's own width
   localparam [AW:0] FULL_COUNT = DEPTH;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   reg [AW:0] count_d;
   wire push;
   wire pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_q];

   always @* begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         count_d = count_q - {{AW{1'b0}}, 1'b1};
      end
   end

   // pointers wrap naturally because depth is a power of two
   always @(posedge clk) begin
      if (rst) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         count_q <= count_d;
         in_ready <= (count_d != FULL_COUNT);
      end
   end

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end
endmodule // crc_sig_fifo

`default_nettype wire

// ### design/crc_sig_engine.v
// 16-bit and 32-bit signature engine fed by queued write requests
`timescale 1ns/100ps
`default_nettype none
`include "crc_sig_regs.vh"

//
// Contract
// RULE1: no interrupt output or flag; signatures only.
// RULE2: separate 16-bit and 32-bit signatures, each with seed, data and result.
// RULE3: seed write loads the start signature, dropping the old one.
// RULE4: normal result gives the signature, bit 0 least significant.
// RULE5: reversed result gives the signature bit-reversed, bit 0 at the top.
// RULE6: normal 8/16-bit data writes fold into the signature, bit 0 least significant.
// RULE7: 32-bit data writes are accepted only in the 32-bit mode.
// RULE8: reversed writes flip bits within each byte, then fold as usual.
// RULE9: software names the mode on every access and keeps it per signature.
// RULE10: 32-bit uses the 802.3 polynomial, 16-bit uses CCITT; no bus stall. WR_READY drops while the 4-entry queue is full.
module crc_sig_engine (
   input wire CLOCK, // system clock, 100 MHz
   input wire RST, // synchronous reset, active high
   input wire WR_VALID, // write request offered
   output wire WR_READY, // request queue has room
   input wire [1:0] WR_KIND, // seed, byte, word or dword
   input wire WR_REV, // data given in bit-reversed form
   input wire WR_MODE, // 0 short signature, 1 long signature
   input wire [31:0] WR_DATA, // seed or data word
   input wire RD_MODE, // signature shown on the result ports
   output reg [31:0] RESULT, // selected signature, normal order
   output reg [31:0] RESULT_REV, // selected signature, reversed order
   output reg IDLE // queue empty and nothing being folded
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // one reflected crc step over a byte; works for either width
   // because the short signature keeps its upper half at zero
   function [31:0] fold_byte;
      input [31:0] crc;
      input [7:0] data;
      input [31:0] poly;
      integer i;
      reg [31:0] c;
      begin
         c = crc ^ {24'h00_0000, data};
         for (i = 0; i < 8; i = i + 1) begin
            if (c[0]) begin
               c = (c >> 1) ^ poly;
            end else begin
               c = c >> 1;
            end
         end
         fold_byte = c;
      end
   endfunction

   function [2:0] byte_count;
      input [1:0] kind;
      begin
         case (kind)
            `KIND_BYTE: byte_count = `BYTES_BYTE;
            `KIND_WORD: byte_count = `BYTES_WORD;
            `KIND_DWORD: byte_count = `BYTES_DWORD;
            default: byte_count = `BYTES_ONE;
         endcase
      end
   endfunction

   wire fifo_ready;
   wire req_valid;
   wire req_ready;
   wire [`REQ_WIDTH-1:0] req;
   wire [1:0] req_kind;
   wire req_rev;
   wire req_mode;
   wire [31:0] req_data;
   wire [31:0] req_data_flip;
   wire [31:0] short_wide;
   wire [31:0] sig_sel;
   wire [31:0] sig_sel_rev;

   reg state_q;
   reg state_d;
   reg [15:0] short_sig_q;
   reg [15:0] short_sig_d;
   reg [31:0] long_sig_q;
   reg [31:0] long_sig_d;
   reg [31:0] buf_q;
   reg [31:0] buf_d;
   reg [2:0] left_q;
   reg [2:0] left_d;
   reg mode_q;
   reg mode_d;
   reg [31:0] folded;

   assign WR_READY = fifo_ready;

   // queueing the writes lets the bus run ahead while bytes fold, until the 4-entry queue fills and WR_READY drops [RULE10]
   crc_sig_fifo #(
      .WIDTH(`REQ_WIDTH),
      .DEPTH(`REQ_DEPTH),
      .AW(2)
   ) i_crc_sig_fifo (
      .clk(CLOCK),
      .rst(RST),
      .in_valid(WR_VALID),
      .in_ready(fifo_ready),
      .in_data({WR_KIND, WR_REV, WR_MODE, WR_DATA}),
      .out_valid(req_valid),
      .out_ready(req_ready),
      .out_data(req)
   );

   assign req_kind = req[`REQ_KIND_MSB:`REQ_KIND_LSB];
   assign req_rev = req[`REQ_REV_BIT];
   assign req_mode = req[`REQ_MODE_BIT];
   assign req_data = req[`REQ_DATA_MSB:`REQ_DATA_LSB];
   assign req_ready = (state_q == ST_IDLE);

   assign short_wide = {16'h0000, short_sig_q};
   assign sig_sel = (RD_MODE == `MODE_LONG) ? long_sig_q : short_wide;

   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : g_flip
         // reversed input: flip bits inside each byte [RULE8]
         assign req_data_flip[g] = req_data[(g / 8) * 8 + 7 - (g % 8)];
      end
      for (g = 0; g < 32; g = g + 1) begin : g_res_rev
         // short signature reversed across its own 16 bits [RULE5]
         if (g < 16) begin : g_lo
            assign sig_sel_rev[g] = (RD_MODE == `MODE_LONG) ?
                                    long_sig_q[31 - g] : short_sig_q[15 - g];
         end else begin : g_hi
            assign sig_sel_rev[g] = (RD_MODE == `MODE_LONG) ? long_sig_q[31 - g] : 1'b0;
         end
      end
   endgenerate

   // the selected mode's polynomial folds the lowest waiting byte [RULE10]
   always @* begin
      if (mode_q == `MODE_LONG) begin
         folded = fold_byte(long_sig_q, buf_q[7:0], `POLY_LONG);
      end else begin
         folded = fold_byte(short_wide, buf_q[7:0], `POLY_SHORT);
      end
   end

   always @* begin
      state_d = state_q;
      short_sig_d = short_sig_q;
      long_sig_d = long_sig_q;
      buf_d = buf_q;
      left_d = left_q;
      mode_d = mode_q;
      case (state_q)
         ST_IDLE: begin
            if (req_valid) begin
               if (req_kind == `KIND_SEED) begin
                  // each mode keeps its own seed and signature [RULE2]
                  if (req_mode == `MODE_LONG) begin
                     long_sig_d = req_data; // [RULE3]
                  end else begin
                     short_sig_d = req_data[15:0]; // [RULE3]
                  end
               end else if (req_kind == `KIND_DWORD && req_mode == `MODE_SHORT) begin
                  // no 32-bit data input in the short mode: dropped [RULE7]
                  state_d = ST_IDLE;
               end else begin
                  // low byte first; normal data keeps bit 0 as lsb [RULE6]
                  buf_d = req_rev ? req_data_flip : req_data; // [RULE8]
                  left_d = byte_count(req_kind);
                  mode_d = req_mode; // [RULE9]
                  state_d = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (mode_q == `MODE_LONG) begin
               long_sig_d = folded; // [RULE6]
            end else begin
               short_sig_d = folded[15:0]; // [RULE6]
            end
            buf_d = buf_q >> 8;
            left_d = left_q - `BYTES_ONE;
            if (left_q == `BYTES_ONE) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         state_q <= ST_IDLE;
         short_sig_q <= `SEED_SHORT_RESET;
         long_sig_q <= `SEED_LONG_RESET;
         buf_q <= 32'h0000_0000;
         left_q <= 3'h0;
         mode_q <= `MODE_SHORT;
      end else begin
         state_q <= state_d;
         short_sig_q <= short_sig_d;
         long_sig_q <= long_sig_d;
         buf_q <= buf_d;
         left_q <= left_d;
         mode_q <= mode_d;
      end
   end

   // results lag the signature by one cycle; no interrupt path exists [RULE1]
   always @(posedge CLOCK) begin
      if (RST) begin
         RESULT <= 32'h0000_0000;
         RESULT_REV <= 32'h0000_0000;
         IDLE <= 1'b0;
      end else begin
         RESULT <= sig_sel; // [RULE4]
         RESULT_REV <= sig_sel_rev; // [RULE5]
         // taken from the current state so idle and the result settle together
         IDLE <= (state_q == ST_IDLE) && !req_valid && !WR_VALID;
      end
   end
endmodule // crc_sig_engine

`default_nettype wire

// ### test/crc_sig_props.sv
// port checker for the signature engine
`timescale 1ns/100ps
`default_nettype none
`include "crc_sig_regs.vh"
module crc_sig_props (
   input wire CLOCK, // clock
   input wire RST, // reset
   input wire WR_VALID, // request
   input wire WR_READY, // room
   input wire [1:0] WR_KIND, // kind
   input wire WR_REV, // reversed data
   input wire WR_MODE, // write mode
   input wire [31:0] WR_DATA, // data
   input wire RD_MODE, // view mode
   input wire [31:0] RESULT, // signature
   input wire [31:0] RESULT_REV, // reversed signature
   input wire IDLE // idle
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   function automatic [31:0] fold(input [31:0] c, input [31:0] d, input r, input m);
      integer i;
      begin
         for (i = 0; i < 8; i++)
            c = (c >> 1) ^ ((c[0] ^ (r ? d[7-i] : d[i])) ? (m ? `POLY_LONG : `POLY_SHORT) : 0);
         fold = c;
      end
   endfunction
   function automatic [31:0] rv(input [31:0] v, input integer n);
      integer i;
      begin
         rv = 32'h0000_0000;
         for (i = 0; i < n; i++) rv[i] = v[n-1-i];
      end
   endfunction
   sequence s_q;
      IDLE && !WR_VALID;
   endsequence
   property p_seed;
      s_q ##1 (WR_VALID && WR_READY && WR_KIND == `KIND_SEED && WR_MODE == RD_MODE)
      ##1 $stable(RD_MODE) [*2] |=>
      RESULT == ($past(WR_DATA, 3) & ($past(RD_MODE) ? 32'hFFFF_FFFF : 32'h0000_FFFF));
   endproperty
   a_seed: assert property (p_seed) else $error("seed not loaded");
   property p_fold;
      s_q ##1 (WR_VALID && WR_READY && WR_KIND == `KIND_BYTE && WR_MODE == RD_MODE)
      ##1 $stable(RD_MODE) [*3] |=>
      RESULT == fold($past(RESULT, 3), $past(WR_DATA, 4), $past(WR_REV, 4), $past(RD_MODE));
   endproperty
   a_fold: assert property (p_fold) else $error("byte fold wrong");
   property p_drop;
      s_q ##1 (WR_VALID && WR_READY && WR_KIND == `KIND_DWORD && !WR_MODE && !RD_MODE)
      ##1 (!WR_VALID && !RD_MODE) [*4] |-> RESULT == $past(RESULT, 3);
   endproperty
   a_drop: assert property (p_drop) else $error("short dword changed signature");
   property p_stable;
      IDLE && !WR_VALID && $stable(RD_MODE) |=> $stable(RESULT);
   endproperty
   a_stable: assert property (p_stable) else $error("signature moved while idle");
   property p_rev_l;
      $past(RD_MODE) |-> RESULT_REV == rv(RESULT, 32);
   endproperty
   a_rev_l: assert property (p_rev_l) else $error("long reversed view wrong");
   property p_rev_s;
      !$past(RD_MODE) |-> RESULT_REV == rv(RESULT, 16) && RESULT[31:16] == 16'h0000;
   endproperty
   a_rev_s: assert property (p_rev_s) else $error("short views wrong");
   property p_rst;
      $past(RST) && !RST |=>
      WR_READY && IDLE && RESULT == ($past(RD_MODE) ? 32'hFFFF_FFFF : 32'h0000_FFFF);
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_full;
      !WR_READY |-> !IDLE;
   endproperty
   a_full: assert property (p_full) else $error("idle while queue full");
   c_drop: cover property (s_q ##1 (WR_VALID && WR_READY && WR_KIND == `KIND_DWORD));
   c_full: cover property (WR_VALID && !WR_READY);
   c_rev: cover property (WR_VALID && WR_READY && WR_REV);
endmodule // crc_sig_props
bind crc_sig_engine crc_sig_props i_crc_sig_props (.CLOCK(CLOCK), .RST(RST),
   .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_KIND(WR_KIND), .WR_REV(WR_REV),
   .WR_MODE(WR_MODE), .WR_DATA(WR_DATA), .RD_MODE(RD_MODE), .RESULT(RESULT),
   .RESULT_REV(RESULT_REV), .IDLE(IDLE));
`default_nettype wire

// ### test/crc_sig_engine_tb.sv
// self-checking bench for the signature engine
`timescale 1ns/100ps
`default_nettype none
`include "crc_sig_regs.vh"
module crc_sig_engine_tb;
   reg CLOCK = 0, RST = 1, WR_VALID = 0, WR_REV = 0, WR_MODE = 0, RD_MODE = 1;
   reg [1:0] WR_KIND = 0;
   reg [31:0] WR_DATA = 0;
   wire WR_READY, IDLE;
   wire [31:0] RESULT, RESULT_REV;
   integer failures = 0, n_compared = 0, cyc = 0, stalls = 0, k;
   reg [31:0] sig [0:1];
   always #5 CLOCK = ~CLOCK;
   crc_sig_engine i_crc_sig_engine (.CLOCK(CLOCK), .RST(RST), .WR_VALID(WR_VALID),
      .WR_READY(WR_READY), .WR_KIND(WR_KIND), .WR_REV(WR_REV), .WR_MODE(WR_MODE),
      .WR_DATA(WR_DATA), .RD_MODE(RD_MODE), .RESULT(RESULT), .RESULT_REV(RESULT_REV),
      .IDLE(IDLE));
   function automatic [31:0] fb(input [31:0] c, input [7:0] b, input r, input m);
      integer i;
      begin
         for (i = 0; i < 8; i++)
            c = (c >> 1) ^ ((c[0] ^ (r ? b[7-i] : b[i])) ? (m ? `POLY_LONG : `POLY_SHORT) : 0);
         fb = c;
      end
   endfunction
   function automatic [31:0] rv(input [31:0] v, input integer n);
      integer i;
      begin
         rv = 32'h0000_0000;
         for (i = 0; i < n; i++) rv[i] = v[n-1-i];
      end
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      begin
         n_compared++;
         if (s !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   task final_report;
      begin
         $display("compared=%0d failures=%0d", n_compared, failures);
         if (failures == 0 && n_compared > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   // leaves the request up so bursts run back to back; look() drops it
   task wr(input [1:0] kd, input r, input m, input [31:0] d);
      integer j;
      begin
         WR_VALID = 1;
         WR_KIND = kd;
         WR_REV = r;
         WR_MODE = m;
         WR_DATA = d;
         // ready is a register, so its value now is what the next edge samples
         while (WR_READY !== 1'b1) begin
            stalls++;
            @(posedge CLOCK);
            #1;
         end
         @(posedge CLOCK);
         #1;
         if (kd == `KIND_SEED) sig[m] = m ? d : d & 32'h0000_FFFF;
         else if (kd != `KIND_DWORD || m)
            for (j = 0; j < (kd == `KIND_BYTE ? 1 : kd == `KIND_WORD ? 2 : 4); j++)
               sig[m] = fb(sig[m], d[8*j +: 8], r, m);
      end
   endtask
   task look(input m);
      integer w;
      begin
         WR_VALID = 0;
         RD_MODE = m;
         for (w = 0; w < 40 && IDLE !== 1'b1; w++) begin
            @(posedge CLOCK);
            #1;
         end
         chk(IDLE, 32'h0000_0001);
         repeat (2) @(posedge CLOCK);
         #1;
         chk(RESULT, sig[m]);
         chk(RESULT_REV, rv(sig[m], m ? 32 : 16));
      end
   endtask
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         final_report;
      end
   end
   initial begin
      repeat (16) @(posedge CLOCK);
      #1 RST = 0;
      repeat (2) @(posedge CLOCK);
      #1;
      sig[0] = 32'h0000_FFFF;
      sig[1] = 32'hFFFF_FFFF;
      look(1);
      look(0);
      // one mode per signature throughout
      for (k = 0; k < 2; k++) begin
         wr(`KIND_SEED, 0, k[0], 32'h1D0F_5A3C); look(k[0]);
         wr(`KIND_BYTE, 0, k[0], 32'h0000_00A5); look(k[0]);
         wr(`KIND_BYTE, 1, k[0], 32'h0000_0031); look(k[0]);
         wr(`KIND_WORD, 0, k[0], 32'h0000_1234);
         wr(`KIND_WORD, 1, k[0], 32'h0000_80F1); look(k[0]);
         wr(`KIND_DWORD, 0, k[0], 32'hDEAD_BEEF); look(k[0]);
         wr(`KIND_DWORD, 1, k[0], 32'h0102_0304); look(k[0]);
      end
      look(0);
      for (k = 0; k < 8; k++) wr(`KIND_DWORD, k[0], 1, {4{k[7:0]}});
      look(1);
      chk(stalls != 0, 32'h0000_0001);
      wr(`KIND_SEED, 0, 1, 32'h0000_0000);
      wr(`KIND_BYTE, 0, 1, 32'h0000_0000); look(1);
      look(0);
      final_report;
   end
endmodule // crc_sig_engine_tb
`default_nettype wire
